// File: hdl/dpa_arbiter.sv
// dual-port cycle arbiter with refresh timing and byte write control
`timescale 1ns/10ps

// Summary of operation
// RL1 - pending refresh beats any port memory cycle
// RL2 - at cycle start, refresh if pending, else ports and hogs decide
// RL3 - refresh raised internally unless external error correction mode
// RL4 - end of refresh starts 30 us disable; pending low meanwhile
// RL5 - pending returns after disable; refresh waits for idle cycle
// RL6 - refresh every 30 us even while a port hogs memory
// RL7 - memory cycle needs a port request plus both hog line states
// RL8 - a refresh or port cycle leaving idle starts the timing chain
// RL9 - chain held cleared while idle, ready for first step
// RL10 - chain steps one tap per time quantum
// RL11 - end-of-cycle tap closes every cycle at 660 ns and clears chain; the code closes each cycle after 7 clocks, 700 ns
// RL12 - no hogs: single requester granted; requests always yield an owner
// RL13 - no hogs, both requesting: port B wins, port A held off
// RL14 - only B hogs: B owns, A locked out
// RL15 - only A hogs: A owns, B locked out
// RL16 - both hogs cancel; requests alone decide, B wins ties
// RL17 - hogging without request owns with cycle inactive
// RL18 - high byte control line writes that byte in granted cycle
// RL19 - low byte control line reads that byte instead
// RL20 - ram strobes gated by write enable and sixth to fourteenth tap
// RL21 - right enable drives both right strobes, left both left strobes
// RL22 - each refresh advances 6-bit refresh row counter
// RL23 - requester holds address stable until acknowledge rises
// RL24 - acknowledge granted port once per finished memory cycle only
module dpa_arbiter (
  // clock and reset
  input  wire logic                                core_clk_in,
  input  wire logic                                rst_in,
  // port a request lines
  input  wire logic                                port_a_mem_request_n_in,
  input  wire logic                                port_a_hog_n_in,
  input  wire logic                                port_a_right_byte_write_in,
  input  wire logic                                port_a_left_byte_write_in,
  // port b request lines
  input  wire logic                                port_b_mem_request_n_in,
  input  wire logic                                port_b_hog_n_in,
  input  wire logic                                port_b_right_byte_write_in,
  input  wire logic                                port_b_left_byte_write_in,
  // mode strap
  input  wire logic                                ext_ecc_mode_in,
  // cycle in progress and acknowledge
  output logic                                     refresh_cycle_n_out,
  output logic                                     port_a_cycle_n_out,
  output logic                                     port_b_cycle_n_out,
  output logic                                     port_a_ack_n_out,
  output logic                                     port_b_ack_n_out,
  // refresh status
  output logic                                     refresh_pending_out,
  output logic [dpa_pkg::REFRESH_ADDR_W-1:0]       refresh_addr_out,
  // cycle timing
  output logic                                     cycle_idle_out,
  output logic                                     end_of_cycle_tap_out,
  // byte enables
  output logic                                     right_write_enable_out,
  output logic                                     left_write_enable_out,
  output logic                                     right_read_enable_out,
  output logic                                     left_read_enable_out,
  // ram write strobes
  output logic                                     right_ram_strobe_one_n_out,
  output logic                                     right_ram_strobe_two_n_out,
  output logic                                     left_ram_strobe_one_n_out,
  output logic                                     left_ram_strobe_two_n_out
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    dpa_pkg::dpa_state_t                 st;
    logic                                own_a;
    logic                                own_b;
    logic                                ack_a_n;
    logic                                ack_b_n;
    logic [dpa_pkg::REFRESH_ADDR_W-1:0]  ref_addr;
    logic [dpa_pkg::DIS_CNT_W-1:0]       dis_cnt;
    logic                                wr_r;
    logic                                wr_l;
    logic                                rd_r;
    logic                                rd_l;
    logic                                strobe_r_n;
    logic                                strobe_l_n;
  } dpa_arb_t;

  localparam logic [dpa_pkg::DIS_CNT_W-1:0] DIS_LOAD =
    dpa_pkg::DIS_CNT_W'(dpa_pkg::REFRESH_DISABLE_CYC);

  dpa_arb_t     s_q;
  dpa_arb_t     s_d;
  dpa_timing_if tmr ();

  // ----------------------------------------------------------------
  // timing chain
  // ----------------------------------------------------------------
  dpa_timing_chain u_chain (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tmr         (tmr)
  );

  // ----------------------------------------------------------------
  // port priority decode
  // ----------------------------------------------------------------
  logic hog_a;
  logic hog_b;
  logic req_a;
  logic req_b;
  logic grant_a;
  logic grant_b;
  logic active_a;
  logic active_b;
  logic refresh_pending;
  logic cycle_idle;

  // active-high copies of the port lines
  assign hog_a = !port_a_hog_n_in;
  assign hog_b = !port_b_hog_n_in;
  assign req_a = !port_a_mem_request_n_in;
  assign req_b = !port_b_mem_request_n_in;

  // ownership from the two hog lines and the two request lines
  always_comb begin
    grant_a = 1'b0;
    grant_b = 1'b0;
    if (hog_b && !hog_a) begin
      grant_b = 1'b1;                             // see RL14
    end else if (hog_a && !hog_b) begin
      grant_a = 1'b1;                             // see RL15
    end else if (req_b) begin
      grant_b = 1'b1;                             // see RL13, see RL16
    end else if (req_a) begin
      grant_a = 1'b1;                             // see RL12, see RL16
    end
  end

  // the owner runs a cycle only while it also requests
  assign active_a = grant_a && req_a;             // see RL7, see RL17
  assign active_b = grant_b && req_b;             // see RL7, see RL17

  // ----------------------------------------------------------------
  // refresh request
  // ----------------------------------------------------------------
  // pending whenever the disable interval is over and refresh is internal
  assign refresh_pending = !ext_ecc_mode_in                           // see RL3
                           && (s_q.dis_cnt == dpa_pkg::DIS_CNT_RST);  // see RL4, see RL5
  assign cycle_idle      = (s_q.st == dpa_pkg::DPA_IDLE);

  // chain runs while any cycle is in progress
  assign tmr.run = !cycle_idle;                   // see RL8

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d            = s_q;
    s_d.ack_a_n    = 1'b1;
    s_d.ack_b_n    = 1'b1;
    s_d.wr_r       = 1'b0;
    s_d.wr_l       = 1'b0;
    s_d.rd_r       = 1'b0;
    s_d.rd_l       = 1'b0;
    s_d.strobe_r_n = 1'b1;
    s_d.strobe_l_n = 1'b1;

    // disable interval counts down toward the next refresh
    if (s_q.dis_cnt != dpa_pkg::DIS_CNT_RST) begin
      s_d.dis_cnt = s_q.dis_cnt - 9'h001;         // see RL6
    end

    unique case (s_q.st)
      dpa_pkg::DPA_IDLE: begin
        // sample refresh first, then the port decode
        if (refresh_pending) begin
          s_d.st    = dpa_pkg::DPA_REFRESH;       // see RL1, see RL2
          s_d.own_a = 1'b0;
          s_d.own_b = 1'b0;
        end else begin
          s_d.own_a = grant_a;                    // see RL2, see RL17
          s_d.own_b = grant_b;
          if (active_b) begin
            s_d.st = dpa_pkg::DPA_PORT_B;
          end else if (active_a) begin
            s_d.st = dpa_pkg::DPA_PORT_A;
          end
        end
      end

      dpa_pkg::DPA_REFRESH: begin
        if (tmr.done) begin
          s_d.st       = dpa_pkg::DPA_IDLE;       // see RL11
          s_d.ref_addr = s_q.ref_addr + 6'h01;    // see RL22
          s_d.dis_cnt  = DIS_LOAD;                // see RL4
        end
      end

      dpa_pkg::DPA_PORT_A: begin
        s_d.wr_r       = port_a_right_byte_write_in;    // see RL18
        s_d.wr_l       = port_a_left_byte_write_in;     // see RL18
        s_d.rd_r       = !port_a_right_byte_write_in;   // see RL19
        s_d.rd_l       = !port_a_left_byte_write_in;    // see RL19
        s_d.strobe_r_n = !(port_a_right_byte_write_in && tmr.write_window); // see RL20
        s_d.strobe_l_n = !(port_a_left_byte_write_in && tmr.write_window);  // see RL20
        if (tmr.done) begin
          s_d.st      = dpa_pkg::DPA_IDLE;        // see RL11
          s_d.ack_a_n = 1'b0;                     // see RL24
          s_d.wr_r    = 1'b0;
          s_d.wr_l    = 1'b0;
          s_d.rd_r    = 1'b0;
          s_d.rd_l    = 1'b0;
        end
      end

      dpa_pkg::DPA_PORT_B: begin
        s_d.wr_r       = port_b_right_byte_write_in;    // see RL18
        s_d.wr_l       = port_b_left_byte_write_in;     // see RL18
        s_d.rd_r       = !port_b_right_byte_write_in;   // see RL19
        s_d.rd_l       = !port_b_left_byte_write_in;    // see RL19
        s_d.strobe_r_n = !(port_b_right_byte_write_in && tmr.write_window); // see RL20
        s_d.strobe_l_n = !(port_b_left_byte_write_in && tmr.write_window);  // see RL20
        if (tmr.done) begin
          s_d.st      = dpa_pkg::DPA_IDLE;        // see RL11
          s_d.ack_b_n = 1'b0;                     // see RL24
          s_d.wr_r    = 1'b0;
          s_d.wr_l    = 1'b0;
          s_d.rd_r    = 1'b0;
          s_d.rd_l    = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q.st         <= dpa_pkg::DPA_IDLE;
      s_q.own_a      <= 1'b0;
      s_q.own_b      <= 1'b0;
      s_q.ack_a_n    <= 1'b1;
      s_q.ack_b_n    <= 1'b1;
      s_q.ref_addr   <= dpa_pkg::REFRESH_ADDR_RST;
      s_q.dis_cnt    <= dpa_pkg::DIS_CNT_RST;
      s_q.wr_r       <= 1'b0;
      s_q.wr_l       <= 1'b0;
      s_q.rd_r       <= 1'b0;
      s_q.rd_l       <= 1'b0;
      s_q.strobe_r_n <= 1'b1;
      s_q.strobe_l_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // cycle in progress levels; owner shows even while its cycle is inactive
  assign refresh_cycle_n_out  = (s_q.st != dpa_pkg::DPA_REFRESH);
  assign port_a_cycle_n_out   = !s_q.own_a;       // see RL12, see RL13
  assign port_b_cycle_n_out   = !s_q.own_b;
  assign port_a_ack_n_out     = s_q.ack_a_n;
  assign port_b_ack_n_out     = s_q.ack_b_n;

  // refresh and timing status
  assign refresh_pending_out  = refresh_pending;
  assign refresh_addr_out     = s_q.ref_addr;
  assign cycle_idle_out       = cycle_idle;
  assign end_of_cycle_tap_out = tmr.end_of_cycle_tap;

  // byte read and write enables
  assign right_write_enable_out = s_q.wr_r;
  assign left_write_enable_out  = s_q.wr_l;
  assign right_read_enable_out  = s_q.rd_r;
  assign left_read_enable_out   = s_q.rd_l;

  // each enable drives both strobes of its byte lane
  assign right_ram_strobe_one_n_out = s_q.strobe_r_n;   // see RL21
  assign right_ram_strobe_two_n_out = s_q.strobe_r_n;   // see RL21
  assign left_ram_strobe_one_n_out  = s_q.strobe_l_n;   // see RL21
  assign left_ram_strobe_two_n_out  = s_q.strobe_l_n;   // see RL21

endmodule

// File: hdl/dpa_pkg.sv
// constants and types shared by the dual-port cycle arbiter
package dpa_pkg;

  // ----------------------------------------------------------------
  // clock and time figures
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 100;
  localparam int TAP_NS              = 25;
  localparam int SIXTH_TAP_NS        = 150;
  localparam int FOURTEENTH_TAP_NS   = 350;
  localparam int CYCLE_NS            = 660;
  localparam int REFRESH_DISABLE_US  = 30;

  // least times round up to whole clock cycles
  localparam int SIXTH_TAP_CYC       = (SIXTH_TAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FOURTEENTH_TAP_CYC  = (FOURTEENTH_TAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC           = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_DISABLE_CYC =
    (REFRESH_DISABLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int TAP_CNT_W           = 4;
  localparam int DIS_CNT_W           = 9;
  localparam int REFRESH_ADDR_W      = 6;
  localparam logic [TAP_CNT_W-1:0]      TAP_CNT_RST      = 4'h0;
  localparam logic [DIS_CNT_W-1:0]      DIS_CNT_RST      = 9'h000;
  localparam logic [REFRESH_ADDR_W-1:0] REFRESH_ADDR_RST = 6'h00;

  // ----------------------------------------------------------------
  // arbiter states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DPA_IDLE    = 4'h1,
    DPA_REFRESH = 4'h2,
    DPA_PORT_A  = 4'h4,
    DPA_PORT_B  = 4'h8
  } dpa_state_t;

endpackage

// File: hdl/dpa_timing_chain.sv
// stepped tap generator for one operating cycle
`timescale 1ns/10ps
module dpa_timing_chain (
  // clock and reset
  input  wire logic   core_clk_in,
  input  wire logic   rst_in,
  // arbiter side
  dpa_timing_if.chain tmr
);

  typedef struct packed {
    logic [dpa_pkg::TAP_CNT_W-1:0] cnt;
  } dpa_chain_t;

  localparam logic [dpa_pkg::TAP_CNT_W-1:0] LAST_TAP =
    dpa_pkg::TAP_CNT_W'(dpa_pkg::CYCLE_CYC - 1);
  localparam logic [dpa_pkg::TAP_CNT_W-1:0] SIXTH =
    dpa_pkg::TAP_CNT_W'(dpa_pkg::SIXTH_TAP_CYC);
  localparam logic [dpa_pkg::TAP_CNT_W-1:0] FOURTEENTH =
    dpa_pkg::TAP_CNT_W'(dpa_pkg::FOURTEENTH_TAP_CYC);

  dpa_chain_t s_q;
  dpa_chain_t s_d;

  // ----------------------------------------------------------------
  // chain advance
  // ----------------------------------------------------------------
  // held cleared while no cycle runs and after the last tap, one tap step per clock otherwise
  always_comb begin
    s_d = s_q;
    if (!tmr.run || tmr.done) begin
      s_d.cnt = dpa_pkg::TAP_CNT_RST;             // see RL9, see RL11
    end else begin
      s_d.cnt = s_q.cnt + 4'h1;                   // see RL10
    end
  end

  // state register
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q.cnt <= dpa_pkg::TAP_CNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // tap decode
  assign tmr.tap_cnt          = s_q.cnt;
  assign tmr.done             = tmr.run && (s_q.cnt == LAST_TAP);     // see RL11
  assign tmr.end_of_cycle_tap = tmr.run && (s_q.cnt != LAST_TAP);
  assign tmr.last_stage_tap_n = (s_q.cnt == dpa_pkg::TAP_CNT_RST);    // see RL9
  assign tmr.write_window     = tmr.run && (s_q.cnt >= SIXTH)
                                && (s_q.cnt < FOURTEENTH);            // see RL20

endmodule

// File: hdl/dpa_timing_if.sv
// carrier between the arbiter and its timing chain
`timescale 1ns/10ps
interface dpa_timing_if;
  logic                          run;
  logic [dpa_pkg::TAP_CNT_W-1:0] tap_cnt;
  logic                          write_window;
  logic                          end_of_cycle_tap;
  logic                          last_stage_tap_n;
  logic                          done;

  modport ctl   (output run, input tap_cnt, write_window, end_of_cycle_tap,
                 last_stage_tap_n, done);
  modport chain (input run, output tap_cnt, write_window, end_of_cycle_tap,
                 last_stage_tap_n, done);
endinterface

// File: verification/dpa_arbiter_checker.sv
// assertion checker watching the dual-port cycle arbiter ports
`timescale 1ns/10ps
module dpa_arbiter_checker (
  // clock and reset
  input wire logic                              core_clk_in,
  input wire logic                              rst_in,
  // port and strap inputs
  input wire logic                              port_b_mem_request_n_in,
  input wire logic                              port_a_hog_n_in,
  input wire logic                              port_b_hog_n_in,
  input wire logic                              ext_ecc_mode_in,
  // cycle, acknowledge and refresh outputs
  input wire logic                              refresh_cycle_n_out,
  input wire logic                              port_a_cycle_n_out,
  input wire logic                              port_b_cycle_n_out,
  input wire logic                              port_a_ack_n_out,
  input wire logic                              port_b_ack_n_out,
  input wire logic                              refresh_pending_out,
  input wire logic [dpa_pkg::REFRESH_ADDR_W-1:0] refresh_addr_out,
  input wire logic                              cycle_idle_out,
  // right lane write path
  input wire logic                              right_write_enable_out,
  input wire logic                              right_ram_strobe_one_n_out,
  input wire logic                              right_ram_strobe_two_n_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  property p_refresh_first;
    cycle_idle_out && refresh_pending_out |=>
      !refresh_cycle_n_out && port_a_cycle_n_out && port_b_cycle_n_out;
  endproperty
  a_refresh_first: assert property (p_refresh_first) else $error("refresh not first");
  property p_b_wins;
    cycle_idle_out && !refresh_pending_out && !port_b_mem_request_n_in
      && (port_a_hog_n_in == port_b_hog_n_in) |=> !port_b_cycle_n_out && port_a_cycle_n_out;
  endproperty
  a_b_wins: assert property (p_b_wins) else $error("port b not granted");
  property p_a_hog;
    cycle_idle_out && !refresh_pending_out && !port_a_hog_n_in && port_b_hog_n_in |=>
      !port_a_cycle_n_out && port_b_cycle_n_out;
  endproperty
  a_a_hog: assert property (p_a_hog) else $error("port a hog not owning");
  property p_b_hog;
    cycle_idle_out && !refresh_pending_out && port_a_hog_n_in && !port_b_hog_n_in |=>
      !port_b_cycle_n_out && port_a_cycle_n_out;
  endproperty
  a_b_hog: assert property (p_b_hog) else $error("port b hog not owning");

  // ----------------------------------------------------------------
  // cycle timing, refresh and strobes
  // ----------------------------------------------------------------
  property p_cycle_len;
    $fell(cycle_idle_out) |-> !cycle_idle_out [*7] ##1 cycle_idle_out;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("cycle length wrong");
  property p_disable;
    $rose(refresh_cycle_n_out) |-> !refresh_pending_out [*8];
  endproperty
  a_disable: assert property (p_disable) else $error("pending after refresh");
  property p_addr_step;
    $rose(refresh_cycle_n_out) |-> refresh_addr_out == $past(refresh_addr_out) + 6'h01;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("refresh row not stepped");
  property p_ack_once;
    ($fell(port_a_ack_n_out) || $fell(port_b_ack_n_out)) |->
      !$past(cycle_idle_out) && cycle_idle_out ##1 port_a_ack_n_out && port_b_ack_n_out;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("acknowledge misplaced");
  property p_strobe;
    $fell(right_ram_strobe_one_n_out) |-> right_write_enable_out && !cycle_idle_out
      && !right_ram_strobe_two_n_out ##1 !right_ram_strobe_one_n_out
      && !right_ram_strobe_two_n_out ##1 right_ram_strobe_one_n_out;
  endproperty
  a_strobe: assert property (p_strobe) else $error("right strobe window wrong");
  property p_ecc;
    ext_ecc_mode_in |-> !refresh_pending_out;
  endproperty
  a_ecc: assert property (p_ecc) else $error("refresh raised with ecc");

  // main scenarios seen
  c_refresh: cover property ($fell(refresh_cycle_n_out));
  c_ack_a: cover property ($fell(port_a_ack_n_out));
  c_write: cover property ($fell(right_ram_strobe_one_n_out));
endmodule

bind dpa_arbiter dpa_arbiter_checker u_dpa_arbiter_checker (
  .core_clk_in, .rst_in, .port_b_mem_request_n_in, .port_a_hog_n_in, .port_b_hog_n_in,
  .ext_ecc_mode_in, .refresh_cycle_n_out, .port_a_cycle_n_out, .port_b_cycle_n_out,
  .port_a_ack_n_out, .port_b_ack_n_out, .refresh_pending_out, .refresh_addr_out,
  .cycle_idle_out, .right_write_enable_out, .right_ram_strobe_one_n_out,
  .right_ram_strobe_two_n_out
);

// File: verification/dpa_proc_model.sv
// processor model standing on one port of the arbiter
`timescale 1ns/10ps
module dpa_proc_model (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_in,
  // commands from the bench
  input  wire logic want_in,
  input  wire logic hog_in,
  input  wire logic right_in,
  input  wire logic left_in,
  // arbiter side
  input  wire logic ack_n_in,
  output logic      mem_request_n_out,
  output logic      hog_n_out,
  output logic      right_byte_write_out,
  output logic      left_byte_write_out
);
  logic acked_q;

  // remember the acknowledge until the bench drops its want
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acked_q <= 1'b0;
    end else begin
      acked_q <= want_in && (acked_q || !ack_n_in);
    end
  end

  // request held until acknowledged, hog and byte lines as commanded
  assign mem_request_n_out    = !(want_in && !acked_q && ack_n_in);
  assign hog_n_out            = !hog_in;
  assign right_byte_write_out = right_in;
  assign left_byte_write_out  = left_in;
endmodule

// File: verification/tb_top.sv
// self-checking bench for the dual-port cycle arbiter
`timescale 1ns/10ps
module tb_top;
  // ----------------------------------------------------------------
  // signals and counters
  // ----------------------------------------------------------------
  logic                               core_clk_in, rst_in, ext_ecc_mode_in;
  logic                               a_want, a_hog, a_right, a_left, a_req_n, a_hog_n;
  logic                               b_want, b_hog, b_right, b_left, b_req_n, b_hog_n;
  logic                               a_rbw, a_lbw, b_rbw, b_lbw, ref_n, a_cyc_n, b_cyc_n;
  logic                               a_ack_n, b_ack_n, pend, idle, eoc, wr_r, wr_l, rd_r;
  logic                               rd_l, sr1_n, sr2_n, sl1_n, sl2_n;
  logic [dpa_pkg::REFRESH_ADDR_W-1:0] raddr;
  int                                 n_mismatch, tests_run, cycles, n_ack_a, n_ack_b;
  int                                 n_ref, n_rstb, n_lstb, n_wr_r, n_wr_l;
  time                                t_ack_a, t_ack_b;

  // design and the two processors
  dpa_arbiter u_dpa_arbiter (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .port_a_mem_request_n_in(a_req_n), .port_a_hog_n_in(a_hog_n),
    .port_a_right_byte_write_in(a_rbw), .port_a_left_byte_write_in(a_lbw),
    .port_b_mem_request_n_in(b_req_n), .port_b_hog_n_in(b_hog_n),
    .port_b_right_byte_write_in(b_rbw), .port_b_left_byte_write_in(b_lbw),
    .ext_ecc_mode_in(ext_ecc_mode_in), .refresh_cycle_n_out(ref_n),
    .port_a_cycle_n_out(a_cyc_n), .port_b_cycle_n_out(b_cyc_n), .port_a_ack_n_out(a_ack_n),
    .port_b_ack_n_out(b_ack_n), .refresh_pending_out(pend), .refresh_addr_out(raddr),
    .cycle_idle_out(idle), .end_of_cycle_tap_out(eoc), .right_write_enable_out(wr_r),
    .left_write_enable_out(wr_l), .right_read_enable_out(rd_r), .left_read_enable_out(rd_l),
    .right_ram_strobe_one_n_out(sr1_n), .right_ram_strobe_two_n_out(sr2_n),
    .left_ram_strobe_one_n_out(sl1_n), .left_ram_strobe_two_n_out(sl2_n));
  dpa_proc_model u_proc_a (.core_clk_in(core_clk_in), .rst_in(rst_in), .want_in(a_want),
    .hog_in(a_hog), .right_in(a_right), .left_in(a_left), .ack_n_in(a_ack_n),
    .mem_request_n_out(a_req_n), .hog_n_out(a_hog_n), .right_byte_write_out(a_rbw),
    .left_byte_write_out(a_lbw));
  dpa_proc_model u_proc_b (.core_clk_in(core_clk_in), .rst_in(rst_in), .want_in(b_want),
    .hog_in(b_hog), .right_in(b_right), .left_in(b_left), .ack_n_in(b_ack_n),
    .mem_request_n_out(b_req_n), .hog_n_out(b_hog_n), .right_byte_write_out(b_rbw),
    .left_byte_write_out(b_lbw));

  // 100 ns clock
  initial begin
    core_clk_in = 1'b0;
    forever #50 core_clk_in = ~core_clk_in;
  end

  // event counters and hang guard
  always @(posedge core_clk_in) begin
    cycles++;
    if (a_ack_n === 1'b0 && n_ack_a == 0) t_ack_a = $time;
    if (b_ack_n === 1'b0 && n_ack_b == 0) t_ack_b = $time;
    n_ack_a += (a_ack_n === 1'b0);
    n_ack_b += (b_ack_n === 1'b0);
    n_ref += ({ref_n, eoc} === 2'b01);
    n_rstb += ({sr1_n, sr2_n} === 2'b00);
    n_lstb += ({sl1_n, sl2_n} === 2'b00);
    n_wr_r += ({wr_r, rd_l} === 2'b11);
    n_wr_l += ({wr_l, rd_r} === 2'b11);
    if (cycles == 6000) begin
      n_mismatch++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask
  task automatic clr();
    {n_ack_a, n_ack_b, n_ref, n_rstb, n_lstb, n_wr_r, n_wr_l} = '0;
  endtask
  task automatic drive(input logic aw, ah, bw, bh);
    @(posedge core_clk_in);
    {a_want, a_hog, b_want, b_hog} <= {aw, ah, bw, bh};
  endtask
  task automatic wait_acks(input int na, nb);
    int lim;
    lim = 60;
    while ((n_ack_a < na || n_ack_b < nb) && lim > 0) begin
      @(negedge core_clk_in);
      lim--;
    end
    @(negedge core_clk_in);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_refresh();
    @(negedge core_clk_in);
    chk(idle === 1'b1 && pend === 1'b1 && raddr === 6'h00 && b_ack_n === 1'b1, "reset");
    clr();
    repeat (12) @(negedge core_clk_in);
    chk(n_ref == 6 && n_ack_a == 0, "no refresh first");
    chk(raddr === 6'h01 && pend === 1'b0, "refresh row or disable");
    $display("test reset_refresh done");
  endtask
  // both want under hog pattern ha/hb, then hogs released
  task automatic t_hog(input logic ha, hb);
    clr();
    drive(1'b1, ha, 1'b1, hb);
    repeat (400) @(negedge core_clk_in);
    chk(n_ref >= 6, "no refresh during hog");
    if (ha != hb) begin
      chk(ha ? (n_ack_a == 1 && n_ack_b == 0 && a_cyc_n === 1'b0 && b_cyc_n === 1'b1)
             : (n_ack_b == 1 && n_ack_a == 0 && b_cyc_n === 1'b0 && a_cyc_n === 1'b1),
          "hog owner or lockout");
    end else begin
      chk(n_ack_a == 1 && n_ack_b == 1 && t_ack_b < t_ack_a, "b not first");
    end
    drive(1'b1, 1'b0, 1'b1, 1'b0);
    wait_acks(1, 1);
    chk(n_ack_a == 1 && n_ack_b == 1, "acknowledge count");
    chk(n_rstb == 2 && n_lstb == 2, "strobe clocks per write");
    chk(n_wr_r > 0 && n_wr_l > 0, "byte write or read enable");
    drive(1'b0, 1'b0, 1'b0, 1'b0);
    $display("test hog %b%b done", ha, hb);
  endtask
  task automatic t_ecc();
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    ext_ecc_mode_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    clr();
    drive(1'b1, 1'b0, 1'b0, 1'b0);
    wait_acks(1, 0);
    chk(n_ack_a == 1 && n_ref == 0 && pend === 1'b0, "refresh taken with ecc");
    repeat (400) @(negedge core_clk_in);
    chk(n_ref == 0, "refresh ran with ecc");
    $display("test ecc done");
  endtask

  // main sequence
  initial begin
    {rst_in, ext_ecc_mode_in, a_want, a_hog, b_want, b_hog} = 6'h20;
    {a_right, a_left, b_right, b_left} = 4'h6;
    repeat (3) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_reset_refresh();
    t_hog(1'b0, 1'b0);
    t_hog(1'b0, 1'b1);
    t_hog(1'b1, 1'b0);
    t_hog(1'b1, 1'b1);
    t_ecc();
    test_done();
  end
endmodule
